// file: es_align_pkg.sv
// shared constants and types for the monitor select / store align control block
`default_nettype none

package es_align_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_LB_TXMON   = 8'ha8;
    localparam logic [7:0] ADDR_ALIGN_RXMON = 8'haa;
    localparam logic [7:0] RESET_LB_TXMON  = 8'h00;
    localparam logic [7:0] RESET_ALIGN_RXMON = 8'h00;

    // ==========================================================
    // field positions
    localparam int LB_BIT       = 7;
    localparam int RX_ALIGN_BIT = 6;
    localparam int TX_ALIGN_BIT = 5;
    localparam int SEL_MSB      = 4;
    localparam int SEL_LSB      = 0;
    localparam int SEL_W        = 5;

    // writable masks; unassigned bits store nothing
    localparam logic [7:0] MASK_LB_TXMON    = 8'h9f;
    localparam logic [7:0] MASK_ALIGN_RXMON = 8'h7f;

    // ==========================================================
    // half a frame of a two-frame store, in store positions
    localparam int FRAME_LEN  = 256;
    localparam int PTR_W      = 9;
    localparam logic [PTR_W-1:0] HALF_FRAME = 9'h080;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef struct packed {
        logic             fire;
        logic [PTR_W-1:0] new_rd_ptr;
    } align_cmd_type;

endpackage

`default_nettype wire

// file: es_align_ctrl.sv
// monitor channel select, remote loopback and elastic store align control
`timescale 1ns/1ps
`default_nettype none

module es_align_ctrl #(
    parameter int PTR_W = es_align_pkg::PTR_W
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    // parallel control port
    input  wire es_align_pkg::host_req_type host_req,
    input  wire logic                 rd,
    input  wire logic [7:0]           rd_addr,
    output logic      [7:0]           rdata,
    // elastic store pointers
    input  wire logic [PTR_W-1:0]     rx_wr_ptr,
    input  wire logic [PTR_W-1:0]     rx_rd_ptr,
    input  wire logic [PTR_W-1:0]     tx_wr_ptr,
    input  wire logic [PTR_W-1:0]     tx_rd_ptr,
    // controls toward the datapath
    output logic                      remote_loopback_en,
    output logic [4:0]                tx_monitor_sel,
    output logic [4:0]                rx_monitor_sel,
    output es_align_pkg::align_cmd_type rx_align,
    output es_align_pkg::align_cmd_type tx_align
);

    // ==========================================================
    // helpers
    // separation measured modulo the two-frame store
    function automatic logic [PTR_W-1:0] ptr_sep(
        input logic [PTR_W-1:0] wr_p,
        input logic [PTR_W-1:0] rd_p
    );
        ptr_sep = wr_p - rd_p;
    endfunction

    function automatic logic is_short(input logic [PTR_W-1:0] sep);
        logic [PTR_W-1:0] back;
        back = -sep;
        is_short = (sep < es_align_pkg::HALF_FRAME) || (back < es_align_pkg::HALF_FRAME);
    endfunction

    // ==========================================================
    // registers
    logic [7:0] lb_txmon_q;
    logic [7:0] align_rxmon_q;
    logic       rx_bit_prev_q;
    logic       tx_bit_prev_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            lb_txmon_q <= es_align_pkg::RESET_LB_TXMON;
        end else if (host_req.wr && host_req.addr == es_align_pkg::ADDR_LB_TXMON) begin
            // unassigned bits are dropped, software keeps them zero
            lb_txmon_q <= host_req.wdata & es_align_pkg::MASK_LB_TXMON;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            align_rxmon_q <= es_align_pkg::RESET_ALIGN_RXMON;
        end else if (host_req.wr && host_req.addr == es_align_pkg::ADDR_ALIGN_RXMON) begin
            align_rxmon_q <= host_req.wdata & es_align_pkg::MASK_ALIGN_RXMON;
        end
    end

    // ==========================================================
    // control outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            remote_loopback_en <= 1'b0;
            tx_monitor_sel     <= 5'h00;
            rx_monitor_sel     <= 5'h00;
        end else begin
            remote_loopback_en <= lb_txmon_q[es_align_pkg::LB_BIT];
            tx_monitor_sel <= lb_txmon_q[es_align_pkg::SEL_MSB:es_align_pkg::SEL_LSB];
            rx_monitor_sel <= align_rxmon_q[es_align_pkg::SEL_MSB:es_align_pkg::SEL_LSB];
        end
    end

    // ==========================================================
    // align edge detection
    // a held bit never refires; software must clear then set
    logic rx_rise;
    logic tx_rise;
    assign rx_rise = align_rxmon_q[es_align_pkg::RX_ALIGN_BIT] && !rx_bit_prev_q;
    assign tx_rise = align_rxmon_q[es_align_pkg::TX_ALIGN_BIT] && !tx_bit_prev_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_bit_prev_q <= 1'b0;
            tx_bit_prev_q <= 1'b0;
        end else begin
            rx_bit_prev_q <= align_rxmon_q[es_align_pkg::RX_ALIGN_BIT];
            tx_bit_prev_q <= align_rxmon_q[es_align_pkg::TX_ALIGN_BIT];
        end
    end

    // ==========================================================
    // align commands
    // the store reloads its read pointer half a frame behind write;
    // backplane clock stability is left to software
    logic rx_short;
    logic tx_short;
    assign rx_short = is_short(ptr_sep(rx_wr_ptr, rx_rd_ptr));
    assign tx_short = is_short(ptr_sep(tx_wr_ptr, tx_rd_ptr));

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_align <= '0;
        end else begin
            rx_align.fire       <= rx_rise && rx_short;
            rx_align.new_rd_ptr <= rx_wr_ptr - es_align_pkg::HALF_FRAME;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tx_align <= '0;
        end else begin
            tx_align.fire       <= tx_rise && tx_short;
            tx_align.new_rd_ptr <= tx_wr_ptr - es_align_pkg::HALF_FRAME;
        end
    end

    // ==========================================================
    // read back
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (rd_addr)
                es_align_pkg::ADDR_LB_TXMON:    rdata <= lb_txmon_q;
                es_align_pkg::ADDR_ALIGN_RXMON: rdata <= align_rxmon_q;
                default:                        rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // checks
    a_rx_align_fire: assert property (@(posedge clk) disable iff (reset)
        (rx_rise && rx_short) |=> rx_align.fire)
        else $error("rx align did not fire on short separation");
    a_tx_align_fire: assert property (@(posedge clk) disable iff (reset)
        (tx_rise && tx_short) |=> tx_align.fire)
        else $error("tx align did not fire on short separation");
    a_rx_no_action: assert property (@(posedge clk) disable iff (reset)
        !rx_short |=> !rx_align.fire)
        else $error("rx align fired with enough separation");
    a_tx_no_action: assert property (@(posedge clk) disable iff (reset)
        !tx_short |=> !tx_align.fire)
        else $error("tx align fired with enough separation");
    a_align_single: assert property (@(posedge clk) disable iff (reset)
        rx_align.fire |=> !rx_align.fire)
        else $error("rx align fired twice without a new edge");
    a_rx_new_ptr: assert property (@(posedge clk) disable iff (reset)
        rx_align.fire |-> rx_align.new_rd_ptr == $past(rx_wr_ptr) - es_align_pkg::HALF_FRAME)
        else $error("rx realign pointer wrong");
    a_tx_single: assert property (@(posedge clk) disable iff (reset)
        tx_align.fire |=> !tx_align.fire)
        else $error("tx align fired twice without a new edge");
    a_tx_new_ptr: assert property (@(posedge clk) disable iff (reset)
        tx_align.fire |-> tx_align.new_rd_ptr == $past(tx_wr_ptr) - es_align_pkg::HALF_FRAME)
        else $error("tx realign pointer wrong");
    // a bit seen high on two samples in a row must stay silent
    a_rx_held_quiet: assert property (@(posedge clk) disable iff (reset)
        (align_rxmon_q[es_align_pkg::RX_ALIGN_BIT]
            && $past(align_rxmon_q[es_align_pkg::RX_ALIGN_BIT])) |=> !rx_align.fire)
        else $error("rx align fired on a held bit");
    a_tx_held_quiet: assert property (@(posedge clk) disable iff (reset)
        (align_rxmon_q[es_align_pkg::TX_ALIGN_BIT]
            && $past(align_rxmon_q[es_align_pkg::TX_ALIGN_BIT])) |=> !tx_align.fire)
        else $error("tx align fired on a held bit");
    a_loopback_map: assert property (@(posedge clk) disable iff (reset)
        (host_req.wr && host_req.addr == es_align_pkg::ADDR_LB_TXMON)
        |=> ##1 remote_loopback_en == $past(host_req.wdata[7], 2))
        else $error("loopback enable does not follow write");
    a_txsel_map: assert property (@(posedge clk) disable iff (reset)
        (host_req.wr && host_req.addr == es_align_pkg::ADDR_LB_TXMON)
        |=> ##1 tx_monitor_sel == $past(host_req.wdata[4:0], 2))
        else $error("tx monitor select does not follow write");
    a_rxsel_map: assert property (@(posedge clk) disable iff (reset)
        (host_req.wr && host_req.addr == es_align_pkg::ADDR_ALIGN_RXMON)
        |=> ##1 rx_monitor_sel == $past(host_req.wdata[4:0], 2))
        else $error("rx monitor select does not follow write");

    // outputs trail the register by one edge, so a control only moves
    // two edges after a write to its own register
    a_loopback_hold: assert property (@(posedge clk) disable iff (reset)
        !(host_req.wr && host_req.addr == es_align_pkg::ADDR_LB_TXMON)
        |=> ##1 $stable(remote_loopback_en))
        else $error("loopback enable changed without a write");
    a_txsel_hold: assert property (@(posedge clk) disable iff (reset)
        !(host_req.wr && host_req.addr == es_align_pkg::ADDR_LB_TXMON)
        |=> ##1 $stable(tx_monitor_sel))
        else $error("tx monitor select changed without a write");
    a_rxsel_hold: assert property (@(posedge clk) disable iff (reset)
        !(host_req.wr && host_req.addr == es_align_pkg::ADDR_ALIGN_RXMON)
        |=> ##1 $stable(rx_monitor_sel))
        else $error("rx monitor select changed without a write");
    a_rd_lb_txmon: assert property (@(posedge clk) disable iff (reset)
        (rd && rd_addr == es_align_pkg::ADDR_LB_TXMON) |=> rdata == $past(lb_txmon_q))
        else $error("read back of loopback register wrong");
    a_rd_align_rxmon: assert property (@(posedge clk) disable iff (reset)
        (rd && rd_addr == es_align_pkg::ADDR_ALIGN_RXMON) |=> rdata == $past(align_rxmon_q))
        else $error("read back of align register wrong");

    // ==========================================================
    // scenario covers
    c_rx_align:  cover property (@(posedge clk) disable iff (reset) rx_align.fire);
    c_tx_align:  cover property (@(posedge clk) disable iff (reset) tx_align.fire);
    c_rx_ignore: cover property (@(posedge clk) disable iff (reset) rx_rise && !rx_short);
    c_tx_ignore: cover property (@(posedge clk) disable iff (reset) tx_rise && !tx_short);
    c_loopback:  cover property (@(posedge clk) disable iff (reset) remote_loopback_en);

endmodule

`default_nettype wire

// file: channel_monitor_es_align_ctrl_tb.sv
// self-checking testbench for the monitor select and store align control block
`timescale 1ns/1ps
`default_nettype none

module channel_monitor_es_align_ctrl_tb;
    // ==========================================================
    // stimulus and observed signals
    logic                        clk = 1'b0;
    logic                        reset = 1'b1;
    es_align_pkg::host_req_type  host_req = '0;
    logic                        rd = 1'b0;
    logic [7:0]                  rd_addr = 8'h00;
    logic [7:0]                  rdata;
    logic [8:0]                  rx_wr_ptr = 9'h000;
    logic [8:0]                  rx_rd_ptr = 9'h000;
    logic [8:0]                  tx_wr_ptr = 9'h000;
    logic [8:0]                  tx_rd_ptr = 9'h000;
    logic                        remote_loopback_en;
    logic [4:0]                  tx_monitor_sel;
    logic [4:0]                  rx_monitor_sel;
    es_align_pkg::align_cmd_type rx_align;
    es_align_pkg::align_cmd_type tx_align;
    int                          error_cnt = 0;
    int                          n_compared = 0;
    int                          rx_fires = 0;
    int                          tx_fires = 0;
    logic [8:0]                  rx_last = 9'h000;
    logic [8:0]                  tx_last = 9'h000;
    logic [4:0]                  sels [4] = '{5'h01, 5'h15, 5'h1f, 5'h00};

    always #50 clk = ~clk;

    es_align_ctrl DUT (
        .clk(clk), .reset(reset), .host_req(host_req), .rd(rd), .rd_addr(rd_addr),
        .rdata(rdata), .rx_wr_ptr(rx_wr_ptr), .rx_rd_ptr(rx_rd_ptr), .tx_wr_ptr(tx_wr_ptr),
        .tx_rd_ptr(tx_rd_ptr), .remote_loopback_en(remote_loopback_en),
        .tx_monitor_sel(tx_monitor_sel), .rx_monitor_sel(rx_monitor_sel),
        .rx_align(rx_align), .tx_align(tx_align)
    );

    // counting every pulse catches a refire that a single sample would miss
    always @(posedge clk) begin
        if (rx_align.fire === 1'b1) begin
            rx_fires <= rx_fires + 1;
            rx_last  <= rx_align.new_rd_ptr;
        end
        if (tx_align.fire === 1'b1) begin
            tx_fires <= tx_fires + 1;
            tx_last  <= tx_align.new_rd_ptr;
        end
    end

    // ==========================================================
    // access and compare tasks, entered and left just after an edge
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // idle cycle after each write keeps the strobe from toggling in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host_req = '{wr: 1'b1, addr: a, wdata: d};
        idle(1);
        host_req.wr = 1'b0;
        idle(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd = 1'b1;
        rd_addr = a;
        idle(1);
        rd = 1'b0;
        idle(1);
        chk({1'b0, rdata}, {1'b0, exp}, "read data");
    endtask

    task automatic align(input logic [7:0] d, input logic er, input logic et);
        int r0;
        int t0;
        r0 = rx_fires;
        t0 = tx_fires;
        wr_reg(8'haa, d);
        // the pulse stands only in the cycle in which the write task returns
        chk({8'h00, rx_align.fire}, {8'h00, er}, "rx fire timing");
        chk({8'h00, tx_align.fire}, {8'h00, et}, "tx fire timing");
        idle(3);
        chk(9'(rx_fires - r0), {8'h00, er}, "rx fire count");
        chk(9'(tx_fires - t0), {8'h00, et}, "tx fire count");
    endtask

    task automatic wrap_up;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // tests
    initial begin
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        chk({8'h00, remote_loopback_en}, 9'h000, "loopback at reset");
        rd_chk(es_align_pkg::ADDR_LB_TXMON, es_align_pkg::RESET_LB_TXMON);
        rd_chk(es_align_pkg::ADDR_ALIGN_RXMON, es_align_pkg::RESET_ALIGN_RXMON);
        rd_chk(8'hab, 8'h00);
        foreach (sels[i]) begin
            wr_reg(8'ha8, {3'b100, sels[i]});
            wr_reg(8'haa, {3'b000, sels[i]});
            chk({8'h00, remote_loopback_en}, 9'h001, "loopback on");
            chk({4'h0, tx_monitor_sel}, {4'h0, sels[i]}, "tx select");
            chk({4'h0, rx_monitor_sel}, {4'h0, sels[i]}, "rx select");
        end
        // unassigned bits are always written as zero
        wr_reg(8'ha8, 8'h9f);
        rd_chk(8'ha8, 8'h9f);
        wr_reg(8'ha8, 8'h03);
        chk({8'h00, remote_loopback_en}, 9'h000, "loopback off");
        wr_reg(8'hab, 8'hff);
        rd_chk(8'ha8, 8'h03);
        // short separation on both stores; the clock has run since time zero
        rx_wr_ptr = 9'h010;
        rx_rd_ptr = 9'h020;
        tx_wr_ptr = 9'h1f0;
        tx_rd_ptr = 9'h1c0;
        align(8'h40, 1'b1, 1'b0);
        chk(rx_last, 9'h190, "rx new read pointer");
        align(8'h40, 1'b0, 1'b0);
        align(8'h60, 1'b0, 1'b1);
        chk(tx_last, 9'h170, "tx new read pointer");
        align(8'h00, 1'b0, 1'b0);
        align(8'h7f, 1'b1, 1'b1);
        rd_chk(8'haa, 8'h7f);
        align(8'h00, 1'b0, 1'b0);
        // exactly half a frame apart is enough
        rx_wr_ptr = 9'h080;
        rx_rd_ptr = 9'h000;
        tx_wr_ptr = 9'h100;
        tx_rd_ptr = 9'h080;
        align(8'h60, 1'b0, 1'b0);
        align(8'h00, 1'b0, 1'b0);
        rx_wr_ptr = 9'h07f;
        align(8'h40, 1'b1, 1'b0);
        chk(rx_last, 9'h1ff, "rx new read pointer");
        wrap_up();
    end

    initial begin
        #(2000 * 100);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
